/* common/pfsa_pkg.sv */
package pfsa_pkg;
   // ==================================================
   // register byte offsets on the bus
   localparam logic [4:0] OFS_ADDR_LOW  = 5'h00;
   localparam logic [4:0] OFS_ADDR_HIGH = 5'h04;
   localparam logic [4:0] OFS_DATA_LOW  = 5'h08;
   localparam logic [4:0] OFS_DATA_HIGH = 5'h0c;
   localparam logic [4:0] OFS_CONTROL   = 5'h10;
   localparam logic [4:0] OFS_UNLOCK    = 5'h14;

   // ==================================================
   // control register bit positions
   localparam int BIT_RD    = 0;
   localparam int BIT_WR    = 1;
   localparam int BIT_WRITE_ENABLE_BIT  = 2;
   localparam int BIT_WRITE_ERROR_FLAG = 3;
   localparam int BIT_FREE  = 4;
   localparam int BIT_LATCH_ONLY_BIT  = 5;
   localparam int BIT_CONFIG_SPACE_SELECT  = 6;

   // ==================================================
   // widths and organisation
   localparam int ADDR_W    = 15;
   localparam int ADDR_HI_W = 7;
   localparam int DATA_W    = 14;
   localparam int DATA_HI_W = 6;
   localparam int LATCH_W   = 5;
   localparam int ROW_W     = 10;
   localparam int ROW_WORDS = 32;
   localparam int MEM_WORDS = 32768;

   localparam logic [DATA_W-1:0] BLANK_WORD = 14'h3fff;
   localparam logic [7:0]        KEY_FIRST  = 8'h55;
   localparam logic [7:0]        KEY_SECOND = 8'haa;

   // ==================================================
   // write protect regions: words below the limit are guarded
   localparam logic [1:0]        WP_NONE    = 2'h3;
   localparam logic [1:0]        WP_LOW     = 2'h2;
   localparam logic [1:0]        WP_HALF    = 2'h1;
   localparam logic [ADDR_W-1:0] WP_LOW_LIM = 15'h0200;
   localparam logic [ADDR_W-1:0] WP_HALF_LIM = 15'h4000;

   // ==================================================
   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int PROG_TIME_NS  = 2000000;
   localparam int PROG_CYCLES   = PROG_TIME_NS / CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_READ,
      ST_NOP1,
      ST_NOP2,
      ST_BUSY
   } pfsa_state_t;

   typedef enum logic [1:0] {
      KEY_NONE,
      KEY_GOT_FIRST,
      KEY_ARMED
   } pfsa_key_t;
endpackage

/* design/pfsa_top.sv */
// Our own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ns
module pfsa_top #(
   parameter int PROG_TIME_CYCLES = pfsa_pkg::PROG_CYCLES
) (
   // clock and resets
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        por_n,
   // avalon-mm slave
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [3:0]  avs_byteenable,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // configuration bits
   input  wire logic        code_protect_bit,
   input  wire logic [1:0]  write_protect_field,
   // core sequencing
   output logic             core_ignore_instr,
   output logic             core_force_nop,
   output logic             core_stall,
   output logic             ext_prog_access_en
);
   // ==================================================
   // reset release
   logic [1:0] rst_sync;
   logic [1:0] por_sync;
   logic       srst_n;
   logic       spor_n;

   // assert at once, release through two flops
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end

   always_ff @(posedge mclk or negedge por_n) begin
      if (!por_n) begin
         por_sync <= 2'h0;
      end else begin
         por_sync <= {por_sync[0], 1'b1};
      end
   end

   assign srst_n = rst_sync[1] & por_sync[1];
   assign spor_n = por_sync[1];

   // ==================================================
   // registers and state
   logic [7:0]                    flash_addr_low;
   logic [pfsa_pkg::ADDR_HI_W-1:0] flash_addr_high;
   logic [7:0]                    flash_data_low;
   logic [pfsa_pkg::DATA_HI_W-1:0] flash_data_high;
   logic                          read_start;
   logic                          write_start;
   logic                          write_enable_bit;
   logic                          write_error_flag;
   logic                          row_erase_bit;
   logic                          latch_only_bit;
   logic                          config_space_select;
   logic                          op_in_flight;
   pfsa_pkg::pfsa_state_t         state;
   pfsa_pkg::pfsa_key_t           key_state;
   logic [31:0]                   timer;
   logic [pfsa_pkg::DATA_W-1:0]   latch [pfsa_pkg::ROW_WORDS];
   logic [pfsa_pkg::DATA_W-1:0]   mem   [pfsa_pkg::MEM_WORDS];

   logic [pfsa_pkg::ADDR_W-1:0]   word_addr;
   logic [pfsa_pkg::LATCH_W-1:0]  latch_idx;
   logic [pfsa_pkg::ROW_W-1:0]    row_idx;
   logic [pfsa_pkg::DATA_W-1:0]   data_word;
   logic                          bus_req;
   logic                          bus_done;
   logic                          wr_done;
   logic                          ctl_wr;
   logic                          key_wr;
   logic                          protected_addr;
   logic                          unlock_ok;
   logic                          latch_load;
   logic                          op_end;
   logic                          load_end;

   assign word_addr = {flash_addr_high, flash_addr_low};
   assign latch_idx = word_addr[pfsa_pkg::LATCH_W-1:0];
   assign row_idx   = word_addr[pfsa_pkg::ADDR_W-1:pfsa_pkg::LATCH_W];
   assign data_word = {flash_data_high, flash_data_low};

   // a request is answered once, only while the sequencer is idle
   assign bus_req  = (avs_read | avs_write) & (state == pfsa_pkg::ST_IDLE);
   assign bus_done = (avs_read | avs_write) & ~avs_waitrequest;
   assign wr_done  = avs_write & ~avs_waitrequest & avs_byteenable[0];
   assign ctl_wr   = wr_done & (avs_address == pfsa_pkg::OFS_CONTROL);
   assign key_wr   = wr_done & (avs_address == pfsa_pkg::OFS_UNLOCK);

   // guarded region chosen by the write protect field
   always_comb begin
      if (write_protect_field == pfsa_pkg::WP_NONE) begin
         protected_addr = 1'b0;
      end else if (write_protect_field == pfsa_pkg::WP_LOW) begin
         protected_addr = (word_addr < pfsa_pkg::WP_LOW_LIM);
      end else if (write_protect_field == pfsa_pkg::WP_HALF) begin
         protected_addr = (word_addr < pfsa_pkg::WP_HALF_LIM);
      end else begin
         protected_addr = 1'b1;
      end
   end

   // write start only counts right after the armed key pair
   assign unlock_ok = ctl_wr & avs_writedata[pfsa_pkg::BIT_WR]
                    & (key_state == pfsa_pkg::KEY_ARMED)
                    & avs_writedata[pfsa_pkg::BIT_WRITE_ENABLE_BIT]
                    & write_enable_bit
                    & ~avs_writedata[pfsa_pkg::BIT_CONFIG_SPACE_SELECT]
                    & ~protected_addr;
   // mode bits come from the same write that sets write start
   assign latch_load = unlock_ok & ~avs_writedata[pfsa_pkg::BIT_FREE];
   assign op_end     = (state == pfsa_pkg::ST_BUSY)
                     & (timer == 32'(PROG_TIME_CYCLES - 1));
   assign load_end   = (state == pfsa_pkg::ST_NOP2) & ~(row_erase_bit | ~latch_only_bit);

   // ==================================================
   // avalon handshake: one wait cycle, then an answer
   always_ff @(posedge mclk or negedge srst_n) begin
      if (!srst_n) begin
         avs_waitrequest <= 1'b1;
      end else if (bus_done) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= ~bus_req;
      end
   end

   // read mux, registered with the answer
   always_ff @(posedge mclk or negedge srst_n) begin
      if (!srst_n) begin
         avs_readdata <= 32'h0;
      end else if (avs_address == pfsa_pkg::OFS_ADDR_LOW) begin
         avs_readdata <= {24'h0, flash_addr_low};
      end else if (avs_address == pfsa_pkg::OFS_ADDR_HIGH) begin
         avs_readdata <= {25'h0, flash_addr_high};
      end else if (avs_address == pfsa_pkg::OFS_DATA_LOW) begin
         avs_readdata <= {24'h0, flash_data_low};
      end else if (avs_address == pfsa_pkg::OFS_DATA_HIGH) begin
         avs_readdata <= {26'h0, flash_data_high};
      end else if (avs_address == pfsa_pkg::OFS_CONTROL) begin
         avs_readdata <= {25'h0, config_space_select, latch_only_bit, row_erase_bit,
                          write_error_flag, write_enable_bit, write_start, read_start};
      end else begin
         avs_readdata <= 32'h0; // unlock key and unmapped read zero
      end
   end

   // ==================================================
   // address pair
   always_ff @(posedge mclk or negedge srst_n) begin
      if (!srst_n) begin
         flash_addr_low  <= 8'h0;
         flash_addr_high <= '0;
      end else if (wr_done && avs_address == pfsa_pkg::OFS_ADDR_LOW) begin
         flash_addr_low  <= avs_writedata[7:0];
      end else if (wr_done && avs_address == pfsa_pkg::OFS_ADDR_HIGH) begin
         flash_addr_high <= avs_writedata[pfsa_pkg::ADDR_HI_W-1:0];
      end
   end

   // data pair: flash read or software write, held otherwise
   always_ff @(posedge mclk or negedge srst_n) begin
      if (!srst_n) begin
         flash_data_low  <= 8'h0;
         flash_data_high <= '0;
      end else if (state == pfsa_pkg::ST_READ) begin
         if (config_space_select) begin
            {flash_data_high, flash_data_low} <= '0;
         end else begin
            {flash_data_high, flash_data_low} <= mem[word_addr];
         end
      end else if (wr_done && avs_address == pfsa_pkg::OFS_DATA_LOW) begin
         flash_data_low  <= avs_writedata[7:0];
      end else if (wr_done && avs_address == pfsa_pkg::OFS_DATA_HIGH) begin
         flash_data_high <= avs_writedata[pfsa_pkg::DATA_HI_W-1:0];
      end
   end

   // ==================================================
   // control bits: start bits are set only, cleared on completion
   always_ff @(posedge mclk or negedge srst_n) begin
      if (!srst_n) begin
         read_start          <= 1'b0;
         write_start         <= 1'b0;
         row_erase_bit       <= 1'b0;
         latch_only_bit      <= 1'b0;
         config_space_select <= 1'b0;
      end else begin
         if (ctl_wr) begin
            row_erase_bit       <= avs_writedata[pfsa_pkg::BIT_FREE];
            latch_only_bit      <= avs_writedata[pfsa_pkg::BIT_LATCH_ONLY_BIT];
            config_space_select <= avs_writedata[pfsa_pkg::BIT_CONFIG_SPACE_SELECT];
         end
         if (state == pfsa_pkg::ST_READ) begin
            read_start <= 1'b0;
         end else if (ctl_wr && avs_writedata[pfsa_pkg::BIT_RD]) begin
            read_start <= 1'b1;
         end
         if (op_end || load_end) begin
            write_start <= 1'b0;
         end else if (unlock_ok) begin
            write_start <= 1'b1;
         end
      end
   end

   // enable and error live through system reset, cleared at power-up
   always_ff @(posedge mclk or negedge spor_n) begin
      if (!spor_n) begin
         write_enable_bit <= 1'b0;
         write_error_flag <= 1'b0;
         op_in_flight     <= 1'b0;
      end else begin
         op_in_flight <= (state == pfsa_pkg::ST_BUSY) & srst_n;
         if (ctl_wr) begin
            write_enable_bit <= avs_writedata[pfsa_pkg::BIT_WRITE_ENABLE_BIT];
         end
         // set wins over a software clear
         if (!srst_n && op_in_flight) begin
            write_error_flag <= 1'b1;
         end else if (ctl_wr) begin
            write_error_flag <= write_error_flag & avs_writedata[pfsa_pkg::BIT_WRITE_ERROR_FLAG];
         end
      end
   end

   // ==================================================
   // unlock key tracker: any other accepted access disarms it
   always_ff @(posedge mclk or negedge srst_n) begin
      if (!srst_n) begin
         key_state <= pfsa_pkg::KEY_NONE;
      end else if (bus_done) begin
         if (key_wr && avs_writedata[7:0] == pfsa_pkg::KEY_FIRST) begin
            key_state <= pfsa_pkg::KEY_GOT_FIRST;
         end else if (key_wr && avs_writedata[7:0] == pfsa_pkg::KEY_SECOND
                      && key_state == pfsa_pkg::KEY_GOT_FIRST) begin
            key_state <= pfsa_pkg::KEY_ARMED;
         end else begin
            key_state <= pfsa_pkg::KEY_NONE;
         end
      end
   end

   // ==================================================
   // sequencer: read slot, forced no-ops, timed operation
   always_ff @(posedge mclk or negedge srst_n) begin
      if (!srst_n) begin
         state <= pfsa_pkg::ST_IDLE;
      end else begin
         case (state)
            pfsa_pkg::ST_IDLE: begin
               if (unlock_ok) begin
                  state <= pfsa_pkg::ST_NOP1;
               end else if (ctl_wr && avs_writedata[pfsa_pkg::BIT_RD]) begin
                  state <= pfsa_pkg::ST_READ;
               end
            end
            pfsa_pkg::ST_READ: begin
               state <= pfsa_pkg::ST_IDLE;
            end
            pfsa_pkg::ST_NOP1: begin
               state <= pfsa_pkg::ST_NOP2;
            end
            pfsa_pkg::ST_NOP2: begin
               if (row_erase_bit || !latch_only_bit) begin
                  state <= pfsa_pkg::ST_BUSY;
               end else begin
                  state <= pfsa_pkg::ST_IDLE;
               end
            end
            pfsa_pkg::ST_BUSY: begin
               if (op_end) begin
                  state <= pfsa_pkg::ST_IDLE;
               end
            end
            default: begin
               state <= pfsa_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // operation timer, runs only while busy
   always_ff @(posedge mclk or negedge srst_n) begin
      if (!srst_n) begin
         timer <= 32'h0;
      end else if (state == pfsa_pkg::ST_BUSY && !op_end) begin
         timer <= timer + 32'h1;
      end else begin
         timer <= 32'h0;
      end
   end

   // core-facing strobes, registered so each is high in the same cycle as its slot state
   always_ff @(posedge mclk or negedge srst_n) begin
      if (!srst_n) begin
         core_ignore_instr  <= 1'b0;
         core_force_nop     <= 1'b0;
         core_stall         <= 1'b0;
         ext_prog_access_en <= 1'b0;
      end else begin
         core_ignore_instr  <= (state == pfsa_pkg::ST_IDLE) & ctl_wr & ~unlock_ok
                             & avs_writedata[pfsa_pkg::BIT_RD];
         core_force_nop     <= ((state == pfsa_pkg::ST_IDLE) & unlock_ok)
                             | (state == pfsa_pkg::ST_NOP1);
         core_stall         <= ((state == pfsa_pkg::ST_NOP2) & (row_erase_bit | ~latch_only_bit))
                             | ((state == pfsa_pkg::ST_BUSY) & ~op_end);
         ext_prog_access_en <= code_protect_bit;
      end
   end

   // ==================================================
   // write latches, one per row word
   generate
      for (genvar i = 0; i < pfsa_pkg::ROW_WORDS; i++) begin : g_latch
         always_ff @(posedge mclk or negedge srst_n) begin
            if (!srst_n) begin
               latch[i] <= pfsa_pkg::BLANK_WORD;
            end else if (op_end) begin
               latch[i] <= pfsa_pkg::BLANK_WORD;
            end else if (latch_load && latch_idx == pfsa_pkg::LATCH_W'(i)) begin
               latch[i] <= data_word;
            end
         end
      end
   endgenerate

   // ==================================================
   // flash array: whole-row erase or row program at the end of the timer
   always_ff @(posedge mclk) begin
      if (op_end) begin
         for (int j = 0; j < pfsa_pkg::ROW_WORDS; j++) begin
            if (row_erase_bit) begin
               mem[{row_idx, pfsa_pkg::LATCH_W'(j)}] <= pfsa_pkg::BLANK_WORD;
            end else begin
               // programming only clears bits, so a blank latch leaves the word
               mem[{row_idx, pfsa_pkg::LATCH_W'(j)}] <=
                  mem[{row_idx, pfsa_pkg::LATCH_W'(j)}] & latch[j];
            end
         end
      end
   end
endmodule // pfsa_top

/* dv/pfsa_top_props.sv */
`timescale 1ns/1ns
// ==================================================
// port checker for the self-access sequencer
module pfsa_top_props #(
   parameter int PROG_TIME_CYCLES = 20
) (
   // clock and resets
   input wire logic        mclk,
   input wire logic        rst_n,
   input wire logic        por_n,
   // register bus
   input wire logic [4:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   // configuration and core sequencing
   input wire logic        code_protect_bit,
   input wire logic [1:0]  write_protect_field,
   input wire logic        core_ignore_instr,
   input wire logic        core_force_nop,
   input wire logic        core_stall,
   input wire logic        ext_prog_access_en
);
   logic [3:0]  up_sr;
   logic [31:0] stall_cnt;
   wire         acc = !avs_waitrequest && avs_write && avs_address == pfsa_pkg::OFS_CONTROL;

   // internal reset lags the pins by two edges, so wait four
   always_ff @(posedge mclk or negedge rst_n or negedge por_n) begin
      if (!rst_n || !por_n) up_sr <= 4'h0;
      else up_sr <= {up_sr[2:0], 1'b1};
   end

   // length of the current stall run
   always_ff @(posedge mclk or negedge rst_n or negedge por_n) begin
      if (!rst_n || !por_n) stall_cnt <= 32'h0;
      else if (!core_stall) stall_cnt <= 32'h0;
      else stall_cnt <= stall_cnt + 32'h1;
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n || !por_n);

   a_nop_pair: assert property (
      $rose(core_force_nop) |=> core_force_nop ##1 !core_force_nop)
      else $error("forced no-op run is not two cycles");
   a_nop_cause: assert property ($rose(core_force_nop) |-> $past(acc && avs_writedata[2]))
      else $error("no-ops without an enabled write start");
   a_read_slot: assert property (
      $rose(core_ignore_instr) |-> $past(acc && avs_writedata[0]) ##1 !core_ignore_instr)
      else $error("read slot not one cycle after read start");
   a_stall_start: assert property (
      $rose(core_stall) |-> $past(core_force_nop) && $past(core_force_nop, 2))
      else $error("stall did not follow two no-ops");
   a_stall_len: assert property ($fell(core_stall) |-> stall_cnt == PROG_TIME_CYCLES)
      else $error("stall length differs from timer");
   a_stall_wait: assert property (core_stall |-> avs_waitrequest)
      else $error("bus answered during stall");
   a_key_zero: assert property (
      avs_read && !avs_waitrequest && avs_address == pfsa_pkg::OFS_UNLOCK
      |-> avs_readdata == 32'h0)
      else $error("unlock key read not zero");
   a_ext_copy: assert property (
      up_sr[3] |-> ext_prog_access_en == $past(code_protect_bit))
      else $error("external access does not follow code protect");
endmodule // pfsa_top_props

bind pfsa_top pfsa_top_props #(.PROG_TIME_CYCLES(PROG_TIME_CYCLES)) u_props (
   .mclk(mclk), .rst_n(rst_n), .por_n(por_n), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
   .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .code_protect_bit(code_protect_bit),
   .write_protect_field(write_protect_field), .core_ignore_instr(core_ignore_instr),
   .core_force_nop(core_force_nop), .core_stall(core_stall),
   .ext_prog_access_en(ext_prog_access_en));

/* dv/pfsa_core_model.sv */
`timescale 1ns/1ns
// ==================================================
// core side: counts slots the sequencer takes from execution
module pfsa_core_model (
   // clock and clear
   input  wire logic mclk,
   input  wire logic clr,
   // sequencing from the block
   input  wire logic core_ignore_instr,
   input  wire logic core_force_nop,
   input  wire logic core_stall,
   // slot counts
   output logic [15:0] n_nop,
   output logic [15:0] n_stall,
   output logic [15:0] n_ign
);
   // core fills forced slots with no-ops and freezes while stalled
   always_ff @(posedge mclk) begin
      if (clr) begin
         n_nop   <= 16'h0;
         n_stall <= 16'h0;
         n_ign   <= 16'h0;
      end else begin
         n_nop   <= n_nop + {15'h0, core_force_nop};
         n_stall <= n_stall + {15'h0, core_stall};
         n_ign   <= n_ign + {15'h0, core_ignore_instr};
      end
   end
endmodule // pfsa_core_model

/* dv/pfsa_top_tb.sv */
`timescale 1ns/1ns
module pfsa_top_tb;
   localparam int         PT   = 20;
   localparam logic [4:0] A_AL = pfsa_pkg::OFS_ADDR_LOW;
   localparam logic [4:0] A_AH = pfsa_pkg::OFS_ADDR_HIGH;
   localparam logic [4:0] A_DL = pfsa_pkg::OFS_DATA_LOW;
   localparam logic [4:0] A_DH = pfsa_pkg::OFS_DATA_HIGH;
   localparam logic [4:0] A_CT = pfsa_pkg::OFS_CONTROL;
   localparam logic [4:0] A_UK = pfsa_pkg::OFS_UNLOCK;
   logic        mclk = 0, rst_n = 0, por_n = 0, avs_read = 0, avs_write = 0, clr = 1;
   logic        code_protect_bit = 1, avs_waitrequest, ign, fnop, stall, ext;
   logic [4:0]  avs_address = 5'h00;
   logic [3:0]  avs_byteenable = 4'hf;
   logic [1:0]  write_protect_field = 2'h3;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
   logic [15:0] n_nop, n_stall, n_ign;
   logic [13:0] w;
   int          n_errors = 0, compares = 0;

   always #5 mclk = ~mclk;

   pfsa_top #(.PROG_TIME_CYCLES(PT)) dut (.mclk(mclk), .rst_n(rst_n), .por_n(por_n),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .code_protect_bit(code_protect_bit), .write_protect_field(write_protect_field),
      .core_ignore_instr(ign), .core_force_nop(fnop), .core_stall(stall),
      .ext_prog_access_en(ext));
   pfsa_core_model core (.mclk(mclk), .clr(clr), .core_ignore_instr(ign),
      .core_force_nop(fnop), .core_stall(stall), .n_nop(n_nop), .n_stall(n_stall),
      .n_ign(n_ign));

   // ==================================================
   // shared tasks
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_write <= wr;
      avs_read <= !wr;
      // sampled at the rising edge, before that edge's updates land
      @(posedge mclk);
      while (avs_waitrequest !== 1'b0 && n < 500) begin
         @(posedge mclk);
         n++;
      end
      if (n >= 500) begin
         n_errors++;
         $display("[ERR] %0t bus wait timed out", $time);
      end
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   task automatic zero;
      @(posedge mclk);
      clr <= 1'b1;
      @(posedge mclk);
      clr <= 1'b0;
   endtask

   task automatic setad(input logic [14:0] a);
      bus(1'b1, A_AL, a[7:0]);
      bus(1'b1, A_AH, {1'b0, a[14:8]});
   endtask

   task automatic unlock(input logic [7:0] ctl);
      bus(1'b1, A_UK, 8'h55);
      bus(1'b1, A_UK, 8'haa);
      bus(1'b1, A_CT, ctl | 8'h02);
      bus(1'b0, A_CT, 8'h00);
   endtask

   task automatic rdw(input logic [14:0] a);
      setad(a);
      bus(1'b1, A_CT, 8'h01);
      bus(1'b0, A_DL, 8'h00);
      w[7:0] = q[7:0];
      bus(1'b0, A_DH, 8'h00);
      w[13:8] = q[5:0];
   endtask

   // ==================================================
   // scenarios
   task automatic t_regs;
      bus(1'b0, A_CT, 8'h00);
      check(q, 32'h0);
      bus(1'b1, A_AH, 8'hff);
      bus(1'b0, A_AH, 8'h00);
      check(q, 32'h7f);
      bus(1'b1, A_DH, 8'hff);
      bus(1'b0, A_DH, 8'h00);
      check(q, 32'h3f);
      bus(1'b1, A_UK, 8'h55);
      bus(1'b0, A_UK, 8'h00);
      check(q, 32'h0);
      bus(1'b0, 5'h18, 8'h00);
      check(q, 32'h0);
      bus(1'b1, A_CT, 8'h02);
      bus(1'b0, A_CT, 8'h00);
      check(q, 32'h0);
      $display("test regs done");
   endtask

   // wrong order, then an access inside the key pair
   task automatic t_lock;
      zero;
      setad(15'h0420);
      bus(1'b1, A_UK, 8'haa);
      bus(1'b1, A_UK, 8'h55);
      bus(1'b1, A_CT, 8'h26);
      bus(1'b1, A_UK, 8'h55);
      bus(1'b0, A_DL, 8'h00);
      bus(1'b1, A_UK, 8'haa);
      bus(1'b1, A_CT, 8'h26);
      bus(1'b0, A_CT, 8'h00);
      check(q, 32'h24);
      check({16'h0, n_nop}, 32'h0);
      $display("test lock done");
   endtask

   task automatic t_prog;
      zero;
      setad(15'h0420);
      bus(1'b1, A_CT, 8'h14);
      unlock(8'h14);
      check({16'h0, n_stall}, PT);
      zero;
      bus(1'b1, A_DL, 8'h34);
      bus(1'b1, A_DH, 8'h12);
      unlock(8'h24);
      check(q, 32'h24);
      check({n_nop, n_stall}, 32'h20000);
      setad(15'h0421);
      bus(1'b1, A_DL, 8'hbc);
      bus(1'b1, A_DH, 8'h2a);
      unlock(8'h04);
      zero;
      rdw(15'h0420);
      check({18'h0, w}, 32'h1234);
      rdw(15'h0421);
      check({18'h0, w}, 32'h2abc);
      rdw(15'h0422);
      check({18'h0, w}, 32'h3fff);
      check({16'h0, n_ign}, 32'h3);
      $display("test prog done");
   endtask

   task automatic t_prot;
      zero;
      write_protect_field <= pfsa_pkg::WP_LOW;
      code_protect_bit <= 1'b0;
      setad(15'h0100);
      bus(1'b1, A_CT, 8'h14);
      unlock(8'h14);
      check(q, 32'h14);
      check({n_nop, 15'h0, ext}, 32'h0);
      write_protect_field <= pfsa_pkg::WP_NONE;
      code_protect_bit <= 1'b1;
      $display("test prot done");
   endtask

   // reset lands in the middle of a row erase
   task automatic t_err;
      setad(15'h0440);
      bus(1'b1, A_CT, 8'h14);
      bus(1'b1, A_UK, 8'h55);
      bus(1'b1, A_UK, 8'haa);
      bus(1'b1, A_CT, 8'h16);
      repeat (6) @(posedge mclk);
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (5) @(posedge mclk);
      bus(1'b0, A_CT, 8'h00);
      check(q & 32'h0e, 32'h0c);
      bus(1'b1, A_CT, 8'h00);
      bus(1'b0, A_CT, 8'h00);
      check(q, 32'h0);
      $display("test err done");
   endtask

   task automatic final_report;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // ==================================================
   // main sequence and watchdog
   initial begin
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      por_n <= 1'b1;
      repeat (4) @(posedge mclk);
      t_regs;
      t_lock;
      t_prog;
      t_prot;
      t_err;
      final_report;
   end

   initial begin
      #200000;
      n_errors++;
      $display("[ERR] %0t watchdog expired", $time);
      final_report;
   end
endmodule // pfsa_top_tb
